// >>> rtl/adf_map.svh
`ifndef ADF_MAP_SVH
`define ADF_MAP_SVH
// register offsets
`define ADF_RESET_REG_ADDR 7'h00
`define ADF_DATA_FORMAT_ADDR 7'h04
// reset register field
`define ADF_SW_RESET_BIT 7
// data format register fields
`define ADF_TP_HI 5
`define ADF_TP_LO 3
`define ADF_ABP_BIT 2
`define ADF_SCRAMBLE_BIT 1
`define ADF_SIGNED_BIT 0
`define ADF_DATA_FORMAT_RST 8'h00
// test pattern codes
`define ADF_TP_OFF 3'h0
`define ADF_TP_ZEROS 3'h1
`define ADF_TP_ONES 3'h3
`define ADF_TP_CHECKER 3'h5
`define ADF_TP_ALTERNATE 3'h7
// serial word length and input FIFO depth
`define ADF_SPI_BITS 5'h10
`define ADF_FIFO_DEPTH 32
`endif

// >>> rtl/adf_pkg.sv
package adf_pkg;
    typedef enum logic [1:0] {
        ADF_SPI_IDLE,
        ADF_SPI_SHIFT,
        ADF_SPI_DONE
    } adf_spi_state_t;
endpackage

// >>> rtl/adf_fifo.sv
`timescale 1ns/10ps
module adf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic do_wr, do_rd;

    // handshake and pointer update
    always_comb
    begin
        in_ready = (cnt_r != (AW+1)'(DEPTH));
        out_valid = (cnt_r != '0);
        do_wr = in_valid && in_ready;
        do_rd = out_valid && out_ready;
        wp_nxt = do_wr ? AW'((wp_r + 1'b1) % DEPTH) : wp_r;
        rp_nxt = do_rd ? AW'((rp_r + 1'b1) % DEPTH) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end

    // storage and pointers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (do_wr)
            mem[wp_r] <= in_data;
    end

    assign out_data = mem[rp_r];
endmodule

// >>> rtl/adf_formatter.sv
`timescale 1ns/10ps
`include "adf_map.svh"
// Overview of operation
// [R1] pattern code 000 passes conversion results
// [R2] code 001 drives controlled bits low
// [R3] code 011 drives controlled bits high
// [R4] code 101 alternates checkerboard and complement
// [R5] code 111 alternates all-low and all-high
// [R6] two low bits never forced by patterns
// [R7] host writes only defined pattern codes
// [R8] bit 2 enables alternate bit polarity
// [R9] bit 1 enables output scrambler
// [R10] bit 0 selects two's complement coding
// [R11] serial word: flag, address, data
// [R12] software reset clears format register, self-clears
// [R13] new format applies from next sample
module adf_formatter
    import adf_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = `ADF_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    input wire logic sample_clk,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic [WIDTH-1:0] sample_data,
    output logic [WIDTH-1:0] sample_output_bus,
    output logic sample_output_valid
);
    // ************************************************
    // pin synchronisers
    // ************************************************
    logic [1:0] cs_s_r, sck_s_r, sdi_s_r, smp_s_r;
    logic sck_d_r, smp_d_r;
    logic sck_rise, sck_fall, smp_rise;

    // two-stage synchronisers for cs_n, sck, sdi and sample_clk
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cs_s_r <= 2'h3;
            sck_s_r <= 2'h0;
            sdi_s_r <= 2'h0;
            smp_s_r <= 2'h0;
            sck_d_r <= 1'b0;
            smp_d_r <= 1'b0;
        end
        else
        begin
            cs_s_r <= {cs_s_r[0], cs_n};
            sck_s_r <= {sck_s_r[0], sck};
            sdi_s_r <= {sdi_s_r[0], sdi};
            smp_s_r <= {smp_s_r[0], sample_clk};
            sck_d_r <= sck_s_r[1];
            smp_d_r <= smp_s_r[1];
        end
    end

    assign sck_rise = sck_s_r[1] && !sck_d_r;
    assign sck_fall = !sck_s_r[1] && sck_d_r;
    assign smp_rise = smp_s_r[1] && !smp_d_r;

    // ************************************************
    // serial configuration port
    // ************************************************
    adf_spi_state_t st_r, st_nxt;
    logic [4:0] bit_cnt_r, bit_cnt_nxt;
    logic [15:0] shift_r, shift_nxt;
    logic [7:0] fmt_r, fmt_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic sdo_r, sdo_nxt;
    logic rd_cmd_r, rd_cmd_nxt;
    logic wr_go;

    // shift in word, decode write, shift out read data
    always_comb
    begin
        st_nxt = st_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        fmt_nxt = fmt_r;
        rd_nxt = rd_r;
        sdo_nxt = sdo_r;
        rd_cmd_nxt = rd_cmd_r;
        wr_go = 1'b0;
        case (st_r)
            ADF_SPI_IDLE:
            begin
                sdo_nxt = 1'b1;
                if (!cs_s_r[1])
                begin
                    st_nxt = ADF_SPI_SHIFT;
                    bit_cnt_nxt = '0;
                end
            end
            ADF_SPI_SHIFT:
            begin
                if (cs_s_r[1])
                    st_nxt = ADF_SPI_IDLE;
                else if (sck_rise)
                begin
                    shift_nxt = {shift_r[14:0], sdi_s_r[1]}; // see [R11]
                    bit_cnt_nxt = bit_cnt_r + 5'h1;
                    // keep the read flag; it leaves the low byte of the shifter
                    if (bit_cnt_r == 5'h0)
                        rd_cmd_nxt = sdi_s_r[1]; // see [R11]
                    if (bit_cnt_r == 5'h7)
                        rd_nxt = ({shift_r[5:0], sdi_s_r[1]} == `ADF_DATA_FORMAT_ADDR)
                            ? fmt_r : 8'h00;
                    if (bit_cnt_r == `ADF_SPI_BITS - 5'h1)
                        st_nxt = ADF_SPI_DONE;
                end
                else if (sck_fall && rd_cmd_r && bit_cnt_r >= 5'h8)
                begin
                    sdo_nxt = rd_r[7]; // see [R11]
                    rd_nxt = {rd_r[6:0], 1'b0};
                end
            end
            ADF_SPI_DONE:
            begin
                // extra sck edges ignored until cs rises
                if (cs_s_r[1])
                begin
                    st_nxt = ADF_SPI_IDLE;
                    wr_go = !shift_r[15]; // see [R11]
                end
            end
            default:
                st_nxt = ADF_SPI_IDLE;
        endcase
        if (wr_go && shift_r[14:8] == `ADF_DATA_FORMAT_ADDR)
            fmt_nxt = shift_r[7:0];
        // reset register write with bit 7 set clears all modes; the bit is never stored
        if (wr_go && shift_r[14:8] == `ADF_RESET_REG_ADDR && shift_r[`ADF_SW_RESET_BIT])
            fmt_nxt = `ADF_DATA_FORMAT_RST; // see [R12]
    end

    // serial port registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_r <= ADF_SPI_IDLE;
            bit_cnt_r <= '0;
            shift_r <= '0;
            fmt_r <= `ADF_DATA_FORMAT_RST;
            rd_r <= '0;
            sdo_r <= 1'b1;
            rd_cmd_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            fmt_r <= fmt_nxt;
            rd_r <= rd_nxt;
            sdo_r <= sdo_nxt;
            rd_cmd_r <= rd_cmd_nxt;
        end
    end

    // open drain: drive only when pulling low
    assign sdo_out = 1'b0;
    assign sdo_oe = !sdo_r;

    // ************************************************
    // sample formatting
    // ************************************************
    logic [WIDTH-1:0] raw_w, fifo_data;
    logic fifo_valid, fifo_ready, fmt_valid;
    logic [WIDTH-1:0] out_r, out_nxt;
    logic vld_r, vld_nxt, phase_r, phase_nxt;
    logic [7:0] act_r, act_nxt;
    logic [2:0] tp;
    logic [7:0] use_fmt;

    // input buffer between source and sample clock
    adf_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(sample_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    assign fifo_ready = smp_rise;
    assign fmt_valid = smp_rise && fifo_valid;

    // pattern word for the low-bit-free part
    function automatic logic [WIDTH-1:0] pattern(input logic [2:0] code,
                                                 input logic ph,
                                                 input logic [WIDTH-1:0] raw);
        logic [WIDTH-1:0] chk;
        chk = '0;
        for (int i = 0; i < WIDTH; i++)
            chk[i] = ~i[0];
        chk = ph ? ~chk : chk;
        pattern = raw;
        case (code)
            `ADF_TP_ZEROS: pattern = '0; // see [R2]
            `ADF_TP_ONES: pattern = '1; // see [R3]
            `ADF_TP_CHECKER: pattern = chk; // see [R4]
            `ADF_TP_ALTERNATE: pattern = ph ? '1 : '0; // see [R5]
            default: pattern = raw; // see [R1]
        endcase
        pattern[1:0] = raw[1:0]; // see [R6]
    endfunction

    // a sample starting now takes the register as it stands at its start
    assign use_fmt = smp_rise ? fmt_r : act_r; // see [R13]
    assign tp = use_fmt[`ADF_TP_HI:`ADF_TP_LO];

    // per-sample transform using the format latched at sample start
    always_comb
    begin
        raw_w = fifo_data;
        if (use_fmt[`ADF_SIGNED_BIT])
            raw_w[WIDTH-1] = ~fifo_data[WIDTH-1]; // see [R10]
        out_nxt = pattern(tp, phase_r, raw_w);
        if (use_fmt[`ADF_SCRAMBLE_BIT])
            out_nxt[WIDTH-1:1] = out_nxt[WIDTH-1:1] ^ {(WIDTH-1){out_nxt[0]}}; // see [R9]
        if (use_fmt[`ADF_ABP_BIT])
            for (int i = 1; i < WIDTH; i += 2)
                out_nxt[i] = ~out_nxt[i]; // see [R8]
        if (!fmt_valid)
            out_nxt = out_r;
        vld_nxt = fmt_valid;
        phase_nxt = fmt_valid ? ~phase_r : phase_r;
        act_nxt = smp_rise ? fmt_r : act_r; // see [R13]
    end

    // output registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            out_r <= '0;
            vld_r <= 1'b0;
            phase_r <= 1'b0;
            act_r <= `ADF_DATA_FORMAT_RST;
        end
        else
        begin
            out_r <= out_nxt;
            vld_r <= vld_nxt;
            phase_r <= phase_nxt;
            act_r <= act_nxt;
        end
    end

    assign sample_output_bus = out_r;
    assign sample_output_valid = vld_r;

    // ************************************************
    // assertions
    // ************************************************
    a_zero_pattern: assert property (@(posedge ref_clk) disable iff (rst) // see [R2]
        fmt_valid && tp == `ADF_TP_ZEROS && use_fmt[2:1] == 2'h0
        |=> sample_output_bus[WIDTH-1:2] == '0)
        else $error("zero pattern wrong");
    a_ones_pattern: assert property (@(posedge ref_clk) disable iff (rst) // see [R3]
        fmt_valid && tp == `ADF_TP_ONES && use_fmt[2:1] == 2'h0
        |=> sample_output_bus[WIDTH-1:2] == '1)
        else $error("ones pattern wrong");
    a_checker_alt: assert property (@(posedge ref_clk) disable iff (rst) // see [R4]
        fmt_valid && tp == `ADF_TP_CHECKER && use_fmt[2:1] == 2'h0
        |=> sample_output_bus[WIDTH-1] == $past(phase_r)
            && sample_output_bus[WIDTH-2] != $past(phase_r))
        else $error("checkerboard wrong");
    a_alt_pattern: assert property (@(posedge ref_clk) disable iff (rst) // see [R5]
        fmt_valid && tp == `ADF_TP_ALTERNATE && use_fmt[2:1] == 2'h0
        |=> sample_output_bus[WIDTH-1:2] == {(WIDTH-2){$past(phase_r)}})
        else $error("alternating pattern wrong");
    a_pass_offset: assert property (@(posedge ref_clk) disable iff (rst) // see [R1]
        fmt_valid && use_fmt[5:0] == 6'h00 |=> sample_output_bus == $past(fifo_data))
        else $error("passthrough wrong");
    a_signed_msb: assert property (@(posedge ref_clk) disable iff (rst) // see [R10]
        fmt_valid && use_fmt[5:0] == 6'h01
        |=> sample_output_bus == {~$past(fifo_data[WIDTH-1]), $past(fifo_data[WIDTH-2:0])})
        else $error("twos complement wrong");
    a_low_bits: assert property (@(posedge ref_clk) disable iff (rst) // see [R6]
        fmt_valid && use_fmt[2:0] == 3'h0 |=> sample_output_bus[1:0] == $past(fifo_data[1:0]))
        else $error("low bits forced");
    a_hold_format: assert property (@(posedge ref_clk) disable iff (rst) // see [R13]
        !fmt_valid |=> !sample_output_valid && $stable(sample_output_bus))
        else $error("output changed between samples");
    a_sw_reset: assert property (@(posedge ref_clk) disable iff (rst) // see [R12]
        wr_go && shift_r[14:8] == 7'h00 && shift_r[7] |=> fmt_r == 8'h00)
        else $error("software reset missed");
    a_read_no_wr: assert property (@(posedge ref_clk) disable iff (rst) // see [R11]
        st_r == ADF_SPI_DONE && shift_r[15] |=> fmt_r == $past(fmt_r))
        else $error("read updated register");
    c_write_fmt: cover property (@(posedge ref_clk) wr_go && shift_r[14:8] == 7'h04);
    c_checker: cover property (@(posedge ref_clk) fmt_valid && tp == `ADF_TP_CHECKER);
    c_read: cover property (@(posedge ref_clk) sdo_oe);
    c_full: cover property (@(posedge ref_clk) !sample_ready);
endmodule

// >>> verif/adf_host.sv
`timescale 1ns/10ps
// ********
// host side of the serial configuration port
// ********
module adf_host (
    input wire logic ref_clk,
    output logic cs_n,
    output logic sck,
    output logic sdi,
    input wire logic sdo_out,
    input wire logic sdo_oe
);
    logic sdo_line;
    // open-drain line with its pull-up
    assign sdo_line = sdo_oe ? sdo_out : 1'b1;
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // one word: flag, address, data; clock idles low outside frames
    task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        logic [15:0] w;
        begin
            w = {rw, a, d};
            q = 8'h00;
            cs_n <= 1'b0;
            for (int i = 15; i >= 0; i--)
            begin
                sdi <= w[i];
                repeat (4) @(posedge ref_clk);
                #1 q = {q[6:0], sdo_line};
                @(posedge ref_clk);
                sck <= 1'b1;
                repeat (3) @(posedge ref_clk);
                sck <= 1'b0;
            end
            repeat (5) @(posedge ref_clk);
            cs_n <= 1'b1;
            sdi <= ~sdi; // released line shows no stale bit
            repeat (8) @(posedge ref_clk);
        end
    endtask
endmodule

// >>> verif/adf_formatter_bench.sv
`timescale 1ns/10ps
`include "adf_map.svh"
// ********
// formatter bench
// ********
module adf_formatter_bench;
    logic ref_clk, rst, cs_n, sck, sdi, sdo_out, sdo_oe;
    logic sample_clk, sample_valid, sample_ready, sample_output_valid;
    logic [15:0] sample_data, sample_output_bus, got, raw;
    logic [7:0] q;
    logic [7:0] fmts [10] = '{8'h00, 8'h08, 8'h18, 8'h28, 8'h38, 8'h04, 8'h02, 8'h01,
                              8'h2d, 8'h3e};
    int failures = 0;
    int total_checks = 0;
    int n;
    bit ph = 0;
    bit took;
    adf_formatter #(.WIDTH(16), .DEPTH(`ADF_FIFO_DEPTH)) uut (.ref_clk(ref_clk), .rst(rst),
        .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .sample_clk(sample_clk), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_data(sample_data), .sample_output_bus(sample_output_bus),
        .sample_output_valid(sample_output_valid));
    adf_host host (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .sdi(sdi),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe));
    // 250 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // expected output word for a format value
    function automatic logic [15:0] fmt(input logic [7:0] f, input logic [15:0] r, input bit p);
        logic [15:0] v;
        v = r;
        // coding acts on the conversion result; patterns then override it
        if (f[0])
            v[15] = ~v[15];
        case (f[5:3])
            3'h1: v[15:2] = 14'h0000;
            3'h3: v[15:2] = 14'h3fff;
            3'h5: v[15:2] = p ? 14'h2aaa : 14'h1555;
            3'h7: v[15:2] = p ? 14'h3fff : 14'h0000;
            default: v = v;
        endcase
        if (f[1])
            v[15:1] = v[15:1] ^ {15{v[0]}};
        if (f[2])
            v = v ^ 16'haaaa;
        return v;
    endfunction
    // offer one word; valid is left high for the caller to drop
    task automatic push(input logic [15:0] w, output bit tk);
        sample_data <= w;
        sample_valid <= 1'b1;
        #1 tk = sample_ready;
        @(posedge ref_clk);
    endtask
    // one sample clock period and the word it emits
    task automatic emit(output logic [15:0] v);
        bit ok;
        ok = 0;
        v = 16'hxxxx;
        sample_clk <= 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            @(posedge ref_clk);
            if (k == 3)
                sample_clk <= 1'b0;
            #1;
            if (!ok && sample_output_valid === 1'b1)
            begin
                ok = 1;
                v = sample_output_bus;
            end
        end
        if (ok)
            ph = ~ph;
    endtask
    // stop a hung run
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        $display("Error watchdog expected finish seen timeout");
        end_of_test();
    end
    // test sequence
    initial
    begin
        rst = 1'b1;
        sample_clk = 1'b0;
        sample_valid = 1'b0;
        sample_data = 16'h0000;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        host.xfer(1'b1, `ADF_DATA_FORMAT_ADDR, 8'h00, q);
        check("format reset", {8'h00, q}, 16'h0000);
        $display("reset test done");
        foreach (fmts[i])
        begin
            host.xfer(1'b0, `ADF_DATA_FORMAT_ADDR, fmts[i], q);
            host.xfer(1'b1, `ADF_DATA_FORMAT_ADDR, 8'h00, q);
            check("format readback", {8'h00, q}, {8'h00, fmts[i]});
            for (int k = 0; k < 3; k++)
            begin
                raw = 16'h9c35 ^ (16'h1111 * i[15:0]) ^ k[15:0];
                push(raw, took);
                sample_valid <= 1'b0;
                emit(got);
                check("sample", got, fmt(fmts[i], raw, ~ph));
            end
        end
        $display("format test done");
        host.xfer(1'b1, `ADF_DATA_FORMAT_ADDR, 8'h15, q);
        check("read ignores data", {8'h00, q}, 16'h003e);
        host.xfer(1'b0, 7'h05, 8'h11, q);
        host.xfer(1'b1, 7'h05, 8'h00, q);
        check("unmapped read", {8'h00, q}, 16'h0000);
        host.xfer(1'b1, `ADF_DATA_FORMAT_ADDR, 8'h00, q);
        check("format kept", {8'h00, q}, 16'h003e);
        $display("refused access test done");
        host.xfer(1'b0, `ADF_RESET_REG_ADDR, 8'h80, q);
        host.xfer(1'b1, `ADF_DATA_FORMAT_ADDR, 8'h00, q);
        check("format cleared", {8'h00, q}, 16'h0000);
        host.xfer(1'b1, `ADF_RESET_REG_ADDR, 8'h00, q);
        check("reset self clear", {8'h00, q}, 16'h0000);
        $display("software reset test done");
        n = 0;
        took = 1;
        while (took && n < 40)
        begin
            push(16'h5a00 ^ n[15:0], took);
            if (took)
                n++;
        end
        sample_valid <= 1'b0;
        check("fifo capacity", n[15:0], 16'h0020);
        for (int j = 0; j < 32; j++)
        begin
            emit(got);
            check("fifo order", got, 16'h5a00 ^ j[15:0]);
        end
        check("ready after drain", {15'h0000, sample_ready}, 16'h0001);
        $display("fifo test done");
        end_of_test();
    end
endmodule
